/* pcg_params.svh */
// register map, field positions, reset values and sizes of the crc generator
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------
`define PCG_OFS_CTRL 12'h000
`define PCG_OFS_TERMS 12'h004
`define PCG_OFS_DATA 12'h008
`define PCG_OFS_RESULT 12'h00C

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define PCG_CTL_IDLE_BIT 13
`define PCG_CTL_COUNT_HI 12
`define PCG_CTL_COUNT_LO 8
`define PCG_CTL_FULL_BIT 7
`define PCG_CTL_EMPTY_BIT 6
`define PCG_CTL_GO_BIT 4
`define PCG_CTL_PLEN_HI 3
`define PCG_CTL_PLEN_LO 0

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define PCG_CTL_RESET 4'h0
`define PCG_TERMS_RESET 16'h0000
`define PCG_RESULT_RESET 16'h0000
`define PCG_DEPTH_WIDE 5'h08
`define PCG_DEPTH_NARROW 5'h10
`define PCG_PLEN_WIDE_ABOVE 4'h7
`define PCG_FIFO_ENTRIES 16
`define PCG_DATA_WIDTH 16

`endif

/* pcg_pkg.sv */
// types shared by the crc generator modules
`default_nettype none
package pcg_pkg;

  // software-written control fields
  typedef struct packed {
    logic stop_in_idle;
    logic shifter_start;
    logic [3:0] poly_length_minus_one;
  } pcg_ctl_t;

  // one step request for the remainder engine
  typedef struct packed {
    logic shift_en;
    logic data_bit;
    logic [3:0] poly_length_minus_one;
    logic [15:0] terms;
  } pcg_step_t;

  // serial shifter position within the head word
  typedef enum logic [0:0] {
    PCG_SH_IDLE,
    PCG_SH_BUSY
  } pcg_sh_state_t;

endpackage
`default_nettype wire

/* pcg_lfsr.sv */
// remainder engine: msb-first feedback shift register with programmable taps
`default_nettype none
`include "pcg_params.svh"
module pcg_lfsr #(
  parameter int WIDTH = `PCG_DATA_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pcg_pkg::pcg_step_t step,
  input wire logic seed_we,
  input wire logic [WIDTH-1:0] seed,
  output logic [WIDTH-1:0] remainder_q
);

  // ----------------------------------------------------------------
  // feedback and next remainder
  // ----------------------------------------------------------------
  logic fb;
  logic [WIDTH-1:0] remainder_d;

  // top bit sits at the programmed length, so short polynomials work unchanged
  assign fb = step.data_bit ^ remainder_q[step.poly_length_minus_one];

  // zero-order term always fed back, enabled taps xor in fb
  assign remainder_d[0] = fb;
  genvar gi;
  generate
    for (gi = 1; gi < WIDTH; gi++) begin : g_tap
      // bits above the length are kept clear so the read value stays clean
      assign remainder_d[gi] = (gi > step.poly_length_minus_one) ? 1'b0 :
                               (remainder_q[gi-1] ^ (fb & step.terms[gi]));
    end
  endgenerate

  // one update per shifted bit; seed load from software wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remainder_q <= `PCG_RESULT_RESET;
    end else if (seed_we) begin
      remainder_q <= seed;
    end else if (step.shift_en) begin
      remainder_q <= remainder_d;
    end
  end

endmodule
`default_nettype wire

/* pcg_top.sv */
// programmable crc generator: apb registers, data fifo, serial shifter
`default_nettype none
`include "pcg_params.svh"
module pcg_top #(
  parameter int DATA_WIDTH = `PCG_DATA_WIDTH,
  parameter int FIFO_ENTRIES = `PCG_FIFO_ENTRIES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  output logic crc_event_pulse
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  // fifo pointers wrap at the live depth through ptr_mask
  pcg_pkg::pcg_ctl_t ctl_q;
  pcg_pkg::pcg_step_t step;
  pcg_pkg::pcg_sh_state_t sh_state_q;
  logic [15:0] terms_q;
  logic [DATA_WIDTH-1:0] fifo_mem [FIFO_ENTRIES];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [4:0] count_q;
  logic [4:0] count_d;
  logic [3:0] bit_idx_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic event_q;
  logic [DATA_WIDTH-1:0] remainder;
  logic [4:0] depth;
  logic [3:0] ptr_mask;
  logic fifo_full;
  logic fifo_empty;
  logic freeze;
  logic access;
  logic wr_fire;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_terms;
  logic wr_data;
  logic wr_result;
  logic msb_lane;
  logic push;
  logic rollover;
  logic shift_en;
  logic head_bit;
  logic last_bit;
  logic pop;
  logic [15:0] ctl_view;
  logic [DATA_WIDTH-1:0] head_word;

  // ----------------------------------------------------------------
  // fifo depth and status flags
  // ----------------------------------------------------------------
  // depth follows the programmed length; wide words halve the storage
  assign depth = (ctl_q.poly_length_minus_one > `PCG_PLEN_WIDE_ABOVE) ?
                 `PCG_DEPTH_WIDE : `PCG_DEPTH_NARROW;
  assign ptr_mask = 4'(depth - 5'h01);
  assign fifo_full = (count_q == depth);
  assign fifo_empty = (count_q == 5'h00);

  // ----------------------------------------------------------------
  // power save freeze
  // ----------------------------------------------------------------
  // sleep always freezes; idle freezes only when software asked for it
  assign freeze = sleep_mode | (idle_mode & ctl_q.stop_in_idle);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // the access phase is always answered in its first cycle
  assign access = psel & penable & pready_q;
  assign wr_fire = access & pwrite;
  assign addr_ok = (paddr == `PCG_OFS_CTRL) || (paddr == `PCG_OFS_TERMS) ||
                   (paddr == `PCG_OFS_DATA) || (paddr == `PCG_OFS_RESULT);
  assign wr_ctrl = wr_fire & (paddr == `PCG_OFS_CTRL);
  assign wr_terms = wr_fire & (paddr == `PCG_OFS_TERMS);
  assign wr_data = wr_fire & (paddr == `PCG_OFS_DATA);
  assign wr_result = wr_fire & (paddr == `PCG_OFS_RESULT);

  // ----------------------------------------------------------------
  // data word push and overflow
  // ----------------------------------------------------------------
  // a word counts only once the lane holding its msb is written
  assign msb_lane = (ctl_q.poly_length_minus_one > `PCG_PLEN_WIDE_ABOVE) ? pstrb[1] : pstrb[0];
  assign push = wr_data & msb_lane;
  assign rollover = push & fifo_full;

  // ----------------------------------------------------------------
  // serial shifter datapath
  // ----------------------------------------------------------------
  assign head_word = fifo_mem[rd_ptr_q];
  // start bit gates the shifter; zero count stops it
  assign shift_en = ctl_q.shifter_start & ~fifo_empty & ~freeze;
  // first bit of a word is its msb at the programmed length
  assign head_bit = (sh_state_q == pcg_pkg::PCG_SH_IDLE) ?
                    head_word[ctl_q.poly_length_minus_one] : head_word[bit_idx_q];
  assign last_bit = (sh_state_q == pcg_pkg::PCG_SH_IDLE) ?
                    (ctl_q.poly_length_minus_one == 4'h0) : (bit_idx_q == 4'h0);
  assign pop = shift_en & last_bit;

  // ----------------------------------------------------------------
  // valid word count next value
  // ----------------------------------------------------------------
  // push and pop on one edge leave the count where it is, unless the push overflows a full fifo and clears it
  always_comb begin
    count_d = count_q;
    if (rollover) begin
      count_d = 5'h00;
    end else if (push && !pop) begin
      count_d = count_q + 5'h01;
    end else if (pop && !push) begin
      count_d = count_q - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // byte lanes respected; reserved and status bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '0;
    end else if (wr_ctrl) begin
      if (pstrb[0]) begin
        ctl_q.shifter_start <= pwdata[`PCG_CTL_GO_BIT];
        ctl_q.poly_length_minus_one <= pwdata[`PCG_CTL_PLEN_HI:`PCG_CTL_PLEN_LO];
      end
      if (pstrb[1]) begin
        ctl_q.stop_in_idle <= pwdata[`PCG_CTL_IDLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // polynomial term enables
  // ----------------------------------------------------------------
  // bit 0 is never stored: the zero term is hard wired
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terms_q <= `PCG_TERMS_RESET;
    end else if (wr_terms) begin
      if (pstrb[0]) begin
        terms_q[7:1] <= pwdata[7:1];
      end
      if (pstrb[1]) begin
        terms_q[15:8] <= pwdata[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // fifo storage
  // ----------------------------------------------------------------
  // no reset on the array; entries are only read once counted valid
  // an overflow write lands in a slot that the cleared pointers abandon
  always_ff @(posedge pclk) begin
    if (wr_data) begin
      if (pstrb[0]) begin
        fifo_mem[wr_ptr_q][7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        fifo_mem[wr_ptr_q][15:8] <= pwdata[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // fifo pointers and count
  // ----------------------------------------------------------------
  // an overflow write restarts the fifo as if empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end else begin
      count_q <= count_d;
      if (rollover) begin
        wr_ptr_q <= 4'h0;
        rd_ptr_q <= 4'h0;
      end else begin
        if (push) begin
          wr_ptr_q <= (wr_ptr_q + 4'h1) & ptr_mask;
        end
        if (pop) begin
          rd_ptr_q <= (rd_ptr_q + 4'h1) & ptr_mask;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shifter state
  // ----------------------------------------------------------------
  // a word stopped midway keeps its bit position and resumes later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_state_q <= pcg_pkg::PCG_SH_IDLE;
      bit_idx_q <= 4'h0;
    end else if (rollover) begin
      sh_state_q <= pcg_pkg::PCG_SH_IDLE;
    end else if (shift_en) begin
      case (sh_state_q)
        pcg_pkg::PCG_SH_IDLE: begin
          if (!last_bit) begin
            sh_state_q <= pcg_pkg::PCG_SH_BUSY;
            bit_idx_q <= ctl_q.poly_length_minus_one - 4'h1;
          end
        end
        pcg_pkg::PCG_SH_BUSY: begin
          if (last_bit) begin
            sh_state_q <= pcg_pkg::PCG_SH_IDLE;
          end else begin
            bit_idx_q <= bit_idx_q - 4'h1;
          end
        end
        default: begin
          sh_state_q <= pcg_pkg::PCG_SH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // remainder engine
  // ----------------------------------------------------------------
  // engine sees the live length and terms; changing them mid-word is unsupported
  assign step.shift_en = shift_en;
  assign step.data_bit = head_bit;
  assign step.poly_length_minus_one = ctl_q.poly_length_minus_one;
  assign step.terms = terms_q;

  // a result write seeds the remainder, so a checksum can start from any value
  pcg_lfsr #(
    .WIDTH(DATA_WIDTH)
  ) u_lfsr (
    .pclk(pclk),
    .presetn(presetn),
    .step(step),
    .seed_we(wr_result),
    .seed(pwdata[15:0]),
    .remainder_q(remainder)
  );

  // ----------------------------------------------------------------
  // drain event
  // ----------------------------------------------------------------
  // only a shift-out from one to zero counts; an overflow never does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= 1'b0;
    end else begin
      event_q <= (count_q == 5'h01) && (count_d == 5'h00) && !rollover;
    end
  end

  // ----------------------------------------------------------------
  // read view of the control register
  // ----------------------------------------------------------------
  // status bits come from live state, so they never disagree with the count
  always_comb begin
    ctl_view = 16'h0000;
    ctl_view[`PCG_CTL_IDLE_BIT] = ctl_q.stop_in_idle;
    ctl_view[`PCG_CTL_COUNT_HI:`PCG_CTL_COUNT_LO] = count_q;
    ctl_view[`PCG_CTL_FULL_BIT] = fifo_full;
    ctl_view[`PCG_CTL_EMPTY_BIT] = fifo_empty;
    ctl_view[`PCG_CTL_GO_BIT] = ctl_q.shifter_start;
    ctl_view[`PCG_CTL_PLEN_HI:`PCG_CTL_PLEN_LO] = ctl_q.poly_length_minus_one;
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // read data is captured in the setup cycle, so it reflects every
  // write that completed before this transfer began
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `PCG_OFS_CTRL: prdata_q <= {16'h0000, ctl_view};
          `PCG_OFS_TERMS: prdata_q <= {16'h0000, terms_q[15:1], 1'b0};
          `PCG_OFS_RESULT: prdata_q <= {16'h0000, remainder};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every port is a flop, so bus timing never depends on decode depth
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign crc_event_pulse = event_q;

endmodule
`default_nettype wire

/* pcg_top_properties.sv */
// concurrent checks on the crc generator's apb and event ports
`default_nettype none
`include "pcg_params.svh"
module pcg_top_properties #(
  parameter int DATA_WIDTH = 16,
  parameter int FIFO_ENTRIES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic crc_event_pulse
);
  // ----------------------------------------------------------------
  // read-back decode; depth follows the length field of the same read
  // ----------------------------------------------------------------
  logic rd_ctl;
  logic rd_terms;
  logic [4:0] depth;
  assign rd_ctl = psel && penable && pready && !pwrite && paddr == `PCG_OFS_CTRL;
  assign rd_terms = psel && penable && pready && !pwrite && paddr == `PCG_OFS_TERMS;
  assign depth = (prdata[3:0] > `PCG_PLEN_WIDE_ABOVE) ? `PCG_DEPTH_WIDE : `PCG_DEPTH_NARROW;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_after_setup;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready not one cycle after setup");
  property p_err_with_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr outside access");
  property p_ctl_reserved;
    rd_ctl |-> prdata[31:14] == 18'h0_0000 && !prdata[5];
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("control reserved bit set");
  property p_terms_bit0;
    rd_terms |-> prdata[31:16] == 16'h0000 && !prdata[0];
  endproperty
  a_terms_bit0: assert property (p_terms_bit0) else $error("term bit zero set");
  property p_empty_flag;
    rd_ctl |-> prdata[6] == (prdata[12:8] == 5'h00);
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag disagrees with count");
  property p_full_flag;
    rd_ctl |-> prdata[7] == (prdata[12:8] == depth);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag disagrees with depth");
  property p_count_max;
    rd_ctl |-> prdata[12:8] <= depth;
  endproperty
  a_count_max: assert property (p_count_max) else $error("count above depth");
  property p_pulse_single;
    crc_event_pulse |=> !crc_event_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("event pulse longer than one cycle");
  // a frozen shifter cannot drain, so no event may follow a sleeping edge
  property p_sleep_no_pulse;
    $past(sleep_mode) |-> !crc_event_pulse;
  endproperty
  a_sleep_no_pulse: assert property (p_sleep_no_pulse) else $error("event while asleep");

  c_full: cover property (rd_ctl && prdata[7]);
  c_pulse: cover property (crc_event_pulse);
  c_err: cover property (pslverr);
endmodule

bind pcg_top pcg_top_properties #(.DATA_WIDTH(DATA_WIDTH), .FIFO_ENTRIES(FIFO_ENTRIES)) i_pcg_top_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep_mode(sleep_mode), .idle_mode(idle_mode), .crc_event_pulse(crc_event_pulse));
`default_nettype wire

/* pcg_tb_top.sv */
// self-checking bench for the crc generator over apb
`default_nettype none
`include "pcg_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pcg_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, idle_mode, crc_event_pulse, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] exp;
  logic [15:0] wq [3] = '{16'h1234, 16'hABCD, 16'h0F0F};
  int n_errors, checks, n_pulse;

  pcg_top i_pcg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .crc_event_pulse(crc_event_pulse));

  // ----------------------------------------------------------------
  // bus tasks and reference model
  // ----------------------------------------------------------------
  // request held until pready is sampled, a bounded wait guards a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic ctl(input logic i, input logic g, input logic [3:0] l);
    apb(1'b1, `PCG_OFS_CTRL, {18'h0_0000, i, 8'h00, g, l}, 4'h3);
  endtask
  task automatic push(input logic [15:0] w);
    apb(1'b1, `PCG_OFS_DATA, {16'h0000, w}, 4'h3);
  endtask
  function automatic logic [31:0] ec(input logic i, input logic [4:0] c, input logic f, input logic e,
                                     input logic g, input logic [3:0] l);
    return {18'h0_0000, i, c, f, e, 1'b0, g, l};
  endfunction
  // msb first from bit len, implicit top and zero terms
  function automatic logic [15:0] crc_ref(input logic [15:0] r, input logic [3:0] l, input logic [15:0] t,
                                          input logic [15:0] w);
    logic fb;
    for (int b = 15; b >= 0; b--) begin
      if (b <= l) begin
        fb = w[b] ^ r[l];
        for (int i = 15; i >= 1; i--) r[i] = (i <= l) ? r[i-1] ^ (fb & t[i]) : 1'b0;
        r[0] = fb;
      end
    end
    return r;
  endfunction
  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, event counter, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (crc_event_pulse === 1'b1) n_pulse++;
  end
  // about 380 cycles are needed, so this leaves wide margin
  initial begin
    repeat (5000) @(posedge pclk);
    $display("watchdog expired");
    n_errors++;
    wrap_up;
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, sleep_mode, idle_mode} = 6'b000000;
    {paddr, pwdata, pstrb} = '0;
    {n_errors, checks, n_pulse} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctl_reset", `PCG_OFS_CTRL, ec(0, 0, 0, 1, 0, 0));
    rchk("terms_reset", `PCG_OFS_TERMS, 32'h0000_0000);
    apb(1'b1, `PCG_OFS_TERMS, 32'hFFFF_FFFF, 4'hF);
    rchk("terms_bit0", `PCG_OFS_TERMS, 32'h0000_FFFE);
    apb(1'b1, `PCG_OFS_CTRL, 32'hFFFF_FFFF, 4'hF);
    rchk("ctl_ro", `PCG_OFS_CTRL, ec(1, 0, 0, 1, 1, 15));
    apb(1'b0, 12'h010, 32'h0000_0000, 4'h0);
    `CHK("unmapped", 1'b1, er)
    $display("registers done");
    ctl(0, 0, 15);
    apb(1'b1, `PCG_OFS_TERMS, 32'h0000_1020, 4'h3);
    apb(1'b1, `PCG_OFS_RESULT, 32'h0000_0000, 4'h3);
    exp = 16'h0000;
    foreach (wq[k]) begin
      push(wq[k]);
      exp = crc_ref(exp, 4'hF, 16'h1020, wq[k]);
    end
    rchk("count3", `PCG_OFS_CTRL, ec(0, 3, 0, 0, 0, 15));
    repeat (20) @(posedge pclk);
    rchk("stopped", `PCG_OFS_CTRL, ec(0, 3, 0, 0, 0, 15));
    ctl(0, 1, 15);
    repeat (46) @(posedge pclk);
    rchk("one_left", `PCG_OFS_CTRL, ec(0, 1, 0, 0, 1, 15));
    rchk("drained", `PCG_OFS_CTRL, ec(0, 0, 0, 1, 1, 15));
    rchk("crc16", `PCG_OFS_RESULT, {16'h0000, exp});
    `CHK("pulse1", 1, n_pulse)
    $display("crc16 done");
    ctl(0, 0, 7);
    apb(1'b1, `PCG_OFS_TERMS, 32'h0000_0006, 4'h3);
    apb(1'b1, `PCG_OFS_RESULT, 32'h0000_0000, 4'h3);
    push(16'h5AA5);
    sleep_mode <= 1'b1;
    idle_mode <= 1'b1;
    ctl(1, 1, 7);
    repeat (20) @(posedge pclk);
    rchk("sleep_hold", `PCG_OFS_CTRL, ec(1, 1, 0, 0, 1, 7));
    sleep_mode <= 1'b0;
    repeat (20) @(posedge pclk);
    rchk("idle_hold", `PCG_OFS_CTRL, ec(1, 1, 0, 0, 1, 7));
    ctl(0, 1, 7);
    repeat (12) @(posedge pclk);
    rchk("idle_run", `PCG_OFS_CTRL, ec(0, 0, 0, 1, 1, 7));
    rchk("crc8", `PCG_OFS_RESULT, {16'h0000, crc_ref(16'h0000, 4'h7, 16'h0006, 16'h00A5)});
    `CHK("pulse2", 2, n_pulse)
    idle_mode <= 1'b0;
    $display("power save done");
    // freeze in mid-word: the word must resume at its bit, not restart
    ctl(0, 0, 7);
    apb(1'b1, `PCG_OFS_RESULT, 32'h0000_00C3, 4'h3);
    push(16'h003C);
    ctl(0, 1, 7);
    repeat (3) @(posedge pclk);
    sleep_mode <= 1'b1;
    repeat (20) @(posedge pclk);
    rchk("mid_hold", `PCG_OFS_CTRL, ec(0, 1, 0, 0, 1, 7));
    sleep_mode <= 1'b0;
    repeat (12) @(posedge pclk);
    rchk("mid_run", `PCG_OFS_CTRL, ec(0, 0, 0, 1, 1, 7));
    rchk("mid_crc", `PCG_OFS_RESULT, {16'h0000, crc_ref(16'h00C3, 4'h7, 16'h0006, 16'h003C)});
    `CHK("pulse3", 3, n_pulse)
    $display("freeze resume done");
    ctl(0, 0, 7);
    for (int k = 0; k < 16; k++) push(16'(k));
    rchk("full16", `PCG_OFS_CTRL, ec(0, 16, 1, 0, 0, 7));
    push(16'h0055);
    rchk("roll16", `PCG_OFS_CTRL, ec(0, 0, 0, 1, 0, 7));
    ctl(0, 0, 15);
    apb(1'b1, `PCG_OFS_DATA, 32'h0000_00FF, 4'h1);
    rchk("low_lane", `PCG_OFS_CTRL, ec(0, 0, 0, 1, 0, 15));
    apb(1'b1, `PCG_OFS_DATA, 32'h0000_FF00, 4'h2);
    rchk("high_lane", `PCG_OFS_CTRL, ec(0, 1, 0, 0, 0, 15));
    repeat (7) push(16'hBEEF);
    rchk("full8", `PCG_OFS_CTRL, ec(0, 8, 1, 0, 0, 15));
    push(16'h1111);
    rchk("roll8", `PCG_OFS_CTRL, ec(0, 0, 0, 1, 0, 15));
    `CHK("no_roll_pulse", 3, n_pulse)
    $display("depth done");
    wrap_up;
  end
endmodule
`default_nettype wire
